// >>> verilog/eep_serial_slave.sv
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// R1: First byte after START is type code, three strap bits, direction bit.
// R2: Select byte arrives MSB first; b7..b4 type, b3..b1 straps, b0 direction.
// R3: Respond only when the received strap bits equal the strap inputs.
// R4: Pull data low in the ninth bit time after each accepted byte.
// R5: Master acknowledges each read byte in the ninth bit time.
// R6: START is data falling while clock high; required before any command.
// R7: Outside programming, watch for START and stay silent until one.
// R8: STOP is data rising while clock high; it ends communication.
// R9: After STOP go to standby until addressed again.
// R10: Master changes data only while clock low.
// R11: Byte write: select, address, one data byte, then programmed.
// R12: Write-mode high accepts up to four data bytes per cycle.
// R13: Write-mode low accepts up to eight bytes in one row.
// R14: Write-mode may change anytime; single byte works at either level.
// R15: Current read returns the byte after the last accessed one.
// R16: Random read: dummy write of address, repeated START, read select.
// R17: Sequential read continues while master acknowledges; up to 256 bytes.
// R18: Storage holds 256 locations of eight bits.
// R19: Data line is only pulled low or released, never driven high.
// R20: Programming cycle is timed internally without serial clocks.
// R21: Master starts every transfer and supplies the clock.
// R22: STOP after a write starts programming; bus ignored meanwhile.
// R23: Page write increments only the three low address bits.
// R24: Master not acknowledging a read byte ends sending.
// R25: Data is sampled on each rising serial clock edge.
// R26: Address byte is a full eight bits and loads the address counter.
module eep_serial_slave #(
    parameter logic [3:0]  TYPE_CODE      = 4'h5, // Arbitrary value.
    parameter int unsigned PROG_SHORT_CYC = eep_pkg::PROG_CYCLES,
    parameter int unsigned PROG_LONG_CYC  = eep_pkg::PROG_LONG_CYCLES
) (
    input  wire logic                       sys_clk,          // System clock.
    input  wire logic                       sys_rst,          // Synchronous reset.
    input  wire logic                       scl,              // Serial clock pin.
    input  wire logic                       sdaIn,            // Serial data pin level.
    output logic                            sdaOut,           // Data drive value.
    output logic                            sdaOe,            // Data pull-low enable.
    input  wire logic                       writeMode,        // Write-mode pin.
    input  wire logic [2:0]                 chipSelectStraps, // Strap pins.
    input  wire logic                       awvalid,          // Write address valid.
    output logic                            awready,          // Write address ready.
    input  wire logic [eep_pkg::REG_AW-1:0] awaddr,           // Write address.
    input  wire logic                       wvalid,           // Write data valid.
    output logic                            wready,           // Write data ready.
    input  wire logic [31:0]                wdata,            // Write data.
    input  wire logic [3:0]                 wstrb,            // Write strobes.
    output logic                            bvalid,           // Response valid.
    input  wire logic                       bready,           // Response ready.
    output logic [1:0]                      bresp,            // Write response.
    input  wire logic                       arvalid,          // Read address valid.
    output logic                            arready,          // Read address ready.
    input  wire logic [eep_pkg::REG_AW-1:0] araddr,           // Read address.
    output logic                            rvalid,           // Read data valid.
    input  wire logic                       rready,           // Read data ready.
    output logic [31:0]                     rdata,            // Read data.
    output logic [1:0]                      rresp             // Read response.
);
    import eep_pkg::*;

    logic                sclS;
    logic                sdaS;
    logic                modeS;
    logic [2:0]          strapS;
    logic                sclPrevQ;
    logic                sdaPrevQ;
    eep_state_type       stQ;
    eep_kind_type        kindQ;
    logic [3:0]          bitCntQ;
    logic [7:0]          shQ;
    logic [7:0]          txQ;
    logic                rwQ;
    logic                ackSeenQ;
    logic [MEM_AW-1:0]   addrQ;
    logic [4:0]          rowQ;
    logic [3:0]          wrCntQ;
    logic                longQ;
    logic                ctrlEnQ;
    logic                progBusy;
    logic [7:0]          memQ [0:MEM_DEPTH-1];
    logic [REG_AW-1:0]   awAddrQ;
    logic [31:0]         wDataQ;
    logic [3:0]          wStrbQ;

    eep_sync #(
        .W       (6),
        .RST_VAL (PIN_RST_VAL)
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .din     ({scl, sdaIn, writeMode, chipSelectStraps}),
        .dout    ({sclS, sdaS, modeS, strapS})
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sclPrevQ <= 1'b1;
            sdaPrevQ <= 1'b1;
        end else begin
            sclPrevQ <= sclS;
            sdaPrevQ <= sdaS;
        end
    end

    wire sclRise  = sclS && !sclPrevQ;
    wire sclFall  = !sclS && sclPrevQ;
    wire startDet = sclS && sclPrevQ && sdaPrevQ && !sdaS; // [R6]
    wire stopDet  = sclS && sclPrevQ && !sdaPrevQ && sdaS; // [R8]

    // Select byte, received MSB first: type code and straps are checked, direction is not.
    wire selOk    = (shQ[7:SEL_TYPE_LSB] == TYPE_CODE) // [R1] [R2]
                 && (shQ[SEL_TYPE_LSB-1:SEL_STRAP_LSB] == strapS) // [R3]
                 && ctrlEnQ;
    // Write-mode is sampled per byte, so it may change at any time.
    wire [3:0] wrLimit = modeS ? MULTI_MAX : PAGE_MAX; // [R12] [R13] [R14]
    wire dataOk   = wrCntQ < wrLimit;
    wire byteEnd  = sclFall && (stQ == ST_RX) && (bitCntQ == BYTE_BITS);
    wire byteAck  = (kindQ == K_SEL) ? selOk : ((kindQ == K_ADDR) || dataOk);
    wire wrStb    = byteEnd && (kindQ == K_DATA) && dataOk && !progBusy;
    wire addrLd   = byteEnd && (kindQ == K_ADDR) && !progBusy;
    wire rdLoad   = sclFall && !progBusy
                 && (((stQ == ST_ACK) && (kindQ == K_SEL) && rwQ)
                  || ((stQ == ST_RXACK) && ackSeenQ));
    wire progGo   = stopDet && (wrCntQ != 4'h0) && !progBusy; // [R22]
    wire [7:0] rdByte = memQ[addrQ];

    eep_prog_timer #(
        .SHORT_CYC (PROG_SHORT_CYC),
        .LONG_CYC  (PROG_LONG_CYC)
    ) u_timer (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (progGo), // [R20]
        .useLong (longQ),
        .busy    (progBusy)
    );

    // Bit-level serial state machine.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stQ      <= ST_IDLE;
            kindQ    <= K_SEL;
            bitCntQ  <= 4'h0;
            shQ      <= 8'h00;
            txQ      <= 8'h00;
            rwQ      <= 1'b0;
            ackSeenQ <= 1'b0;
            sdaOe    <= 1'b0;
        end else if (progBusy) begin
            stQ   <= ST_IDLE; // [R22] [R7]
            sdaOe <= 1'b0;
        end else if (startDet) begin
            stQ     <= ST_RX; // [R6]
            kindQ   <= K_SEL;
            bitCntQ <= 4'h0;
            sdaOe   <= 1'b0;
        end else if (stopDet) begin
            stQ   <= ST_IDLE; // [R8] [R9]
            sdaOe <= 1'b0;
        end else begin
            case (stQ)
                ST_RX: begin
                    if (sclRise && (bitCntQ != BYTE_BITS)) begin
                        shQ     <= {shQ[6:0], sdaS}; // [R25]
                        bitCntQ <= bitCntQ + 4'h1;
                    end else if (byteEnd) begin
                        if (byteAck) begin
                            stQ   <= ST_ACK; // [R4]
                            sdaOe <= 1'b1;
                            if (kindQ == K_SEL) begin
                                rwQ <= shQ[SEL_RW_BIT];
                            end
                        end else begin
                            stQ <= ST_IDLE; // [R3]
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        if ((kindQ == K_SEL) && rwQ) begin
                            stQ     <= ST_TX; // [R15]
                            txQ     <= {rdByte[6:0], 1'b0};
                            sdaOe   <= !rdByte[7]; // [R19]
                            bitCntQ <= 4'h1;
                        end else begin
                            stQ     <= ST_RX;
                            sdaOe   <= 1'b0;
                            bitCntQ <= 4'h0;
                            kindQ   <= (kindQ == K_SEL) ? K_ADDR : K_DATA; // [R11]
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (bitCntQ == BYTE_BITS) begin
                            stQ   <= ST_RXACK;
                            sdaOe <= 1'b0;
                        end else begin
                            sdaOe   <= !txQ[7]; // [R19]
                            txQ     <= {txQ[6:0], 1'b0};
                            bitCntQ <= bitCntQ + 4'h1;
                        end
                    end
                end
                ST_RXACK: begin
                    if (sclRise) begin
                        ackSeenQ <= !sdaS; // [R5]
                    end else if (sclFall) begin
                        if (ackSeenQ) begin
                            stQ     <= ST_TX; // [R17]
                            txQ     <= {rdByte[6:0], 1'b0};
                            sdaOe   <= !rdByte[7];
                            bitCntQ <= 4'h1;
                        end else begin
                            stQ <= ST_IDLE; // [R24]
                        end
                    end
                end
                default: begin
                    stQ   <= ST_IDLE; // [R7]
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: the drive value never leaves zero.
    always_ff @(posedge sys_clk) begin
        sdaOut <= 1'b0; // [R19]
    end

    // Address counter; eight bits span all 256 locations and wrap.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addrQ <= 8'h00;
            rowQ  <= 5'h00;
        end else if (addrLd) begin
            addrQ <= shQ; // [R26] [R16]
            rowQ  <= shQ[MEM_AW-1:ROW_LSB];
        end else if (wrStb && !modeS) begin
            addrQ[ROW_LSB-1:0] <= addrQ[ROW_LSB-1:0] + 3'h1; // [R23]
        end else if (wrStb || rdLoad) begin
            addrQ <= addrQ + 8'h01; // [R15] [R17]
        end
    end

    // Write counting and doubled time for a multibyte row crossing.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wrCntQ <= 4'h0;
            longQ  <= 1'b0;
        end else if (startDet || progGo) begin
            wrCntQ <= 4'h0;
            longQ  <= progGo && longQ;
        end else if (wrStb) begin
            wrCntQ <= wrCntQ + 4'h1; // [R12] [R13]
            if (modeS && (addrQ[MEM_AW-1:ROW_LSB] != rowQ)) begin
                longQ <= 1'b1;
            end
        end
    end

    // Bytes land in the array as they are accepted; the busy time
    // that follows STOP models the cell programming.
    always_ff @(posedge sys_clk) begin
        if (wrStb) begin
            memQ[addrQ] <= shQ; // [R18] [R11]
        end
    end

    // Register bus, write side: address and data in either order.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            awAddrQ <= '0;
            wDataQ  <= 32'h0;
            wStrbQ  <= 4'h0;
            ctrlEnQ <= CTRL_EN_RESET;
        end else begin
            if (awvalid && awready) begin
                awAddrQ <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wDataQ <= wdata;
                wStrbQ <= wstrb;
                wready <= 1'b0;
            end
            if (!awready && !wready && !bvalid) begin
                bvalid <= 1'b1;
                if (awAddrQ == REG_CTRL) begin
                    bresp <= RESP_OKAY;
                    if (wStrbQ[0]) begin
                        ctrlEnQ <= wDataQ[CTRL_EN_BIT];
                    end
                end else if (awAddrQ == REG_STATUS) begin
                    bresp <= RESP_OKAY;
                end else begin
                    bresp <= RESP_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Register bus, read side.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= 32'h0;
            rresp   <= RESP_OKAY;
            if (araddr == REG_CTRL) begin
                rdata[CTRL_EN_BIT] <= ctrlEnQ;
            end else if (araddr == REG_STATUS) begin
                rdata[STAT_BUSY_BIT]                  <= progBusy;
                rdata[STAT_ACTIVE_BIT]                <= stQ != ST_IDLE;
                rdata[STAT_MODE_BIT]                  <= modeS;
                rdata[STAT_ADDR_LSB+MEM_AW-1:STAT_ADDR_LSB] <= addrQ;
                rdata[STAT_CNT_LSB+3:STAT_CNT_LSB]    <= wrCntQ;
            end else begin
                rresp <= RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence masterNack;
        (stQ == ST_RXACK) && sclRise && sdaS && !progBusy && !stopDet;
    endsequence

    sequence nackFall;
        sclFall && !ackSeenQ && (stQ == ST_RXACK);
    endsequence

    ack_ninth_bit_a: assert property ((stQ == ST_ACK) |-> sdaOe) // [R4]
        else $error("Acknowledge not driven in ninth bit.");
    start_begins_rx_a: assert property ( // [R6]
        (startDet && !progBusy) |=> (stQ == ST_RX) && (bitCntQ == 4'h0) && !sdaOe)
        else $error("START did not begin receiving.");
    stop_ends_a: assert property (stopDet |=> (stQ == ST_IDLE) && !sdaOe) // [R8]
        else $error("STOP did not end communication.");
    strap_mismatch_a: assert property ( // [R3]
        (byteEnd && (kindQ == K_SEL) && (shQ[3:1] != strapS) && !progBusy)
        |=> (stQ == ST_IDLE) && !sdaOe)
        else $error("Mismatched straps were answered.");
    busy_silent_a: assert property (progBusy |=> !sdaOe && (stQ == ST_IDLE)) // [R22]
        else $error("Bus answered during programming.");
    prog_start_a: assert property (progGo |=> progBusy && (wrCntQ == 4'h0)) // [R22]
        else $error("Programming did not start after write STOP.");
    page_wrap_a: assert property ( // [R23]
        (wrStb && !modeS) |=> (addrQ[7:3] == $past(addrQ[7:3])))
        else $error("Page write left its row.");
    multi_limit_a: assert property ((modeS && (wrCntQ >= MULTI_MAX)) |-> !wrStb) // [R12]
        else $error("More than four bytes taken in multibyte mode.");
    open_drain_a: assert property (##1 !sdaOut) // [R19]
        else $error("Data line driven high.");
    read_nack_a: assert property (nackFall |=> (stQ == ST_IDLE) && !sdaOe) // [R24]
        else $error("Sending continued after no acknowledge.");
    nack_seen_a: assert property (masterNack |=> !ackSeenQ) // [R24]
        else $error("Missing acknowledge was not noticed.");
endmodule : eep_serial_slave

// >>> verilog/eep_pkg.sv
package eep_pkg;
    // Serial clock domain is sampled by the 200 MHz system clock.
    localparam int unsigned CLK_KHZ          = 200000;
    localparam int unsigned PROG_TIME_MS     = 10;
    localparam int unsigned PROG_LONG_MS     = 20;
    localparam int unsigned PROG_CYCLES      = PROG_TIME_MS * CLK_KHZ;
    localparam int unsigned PROG_LONG_CYCLES = PROG_LONG_MS * CLK_KHZ;

    localparam int          MEM_DEPTH      = 256;
    localparam int          MEM_AW         = 8;
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [3:0]  MULTI_MAX      = 4'h4;
    localparam logic [3:0]  PAGE_MAX       = 4'h8;
    localparam int          SEL_RW_BIT     = 0;
    localparam int          SEL_STRAP_LSB  = 1;
    localparam int          SEL_TYPE_LSB   = 4;
    localparam int          ROW_LSB        = 3;
    localparam logic [5:0]  PIN_RST_VAL    = 6'h30;

    localparam int          REG_AW          = 8;
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_STATUS      = 8'h04;
    localparam int          CTRL_EN_BIT     = 0;
    localparam logic        CTRL_EN_RESET   = 1'h1;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_ACTIVE_BIT = 1;
    localparam int          STAT_MODE_BIT   = 2;
    localparam int          STAT_ADDR_LSB   = 8;
    localparam int          STAT_CNT_LSB    = 16;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_RX    = 5'h02,
        ST_ACK   = 5'h04,
        ST_TX    = 5'h08,
        ST_RXACK = 5'h10
    } eep_state_type;

    typedef enum logic [2:0] {
        K_SEL  = 3'h1,
        K_ADDR = 3'h2,
        K_DATA = 3'h4
    } eep_kind_type;
endpackage : eep_pkg

// >>> verilog/eep_sync.sv
`timescale 1ns/1ps
module eep_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk, // System clock.
    input  wire logic         sys_rst, // Synchronous reset.
    input  wire logic [W-1:0] din,     // Asynchronous inputs.
    output logic      [W-1:0] dout     // Synchronised outputs.
);
    logic [W-1:0] stage1Q;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1Q <= RST_VAL;
            dout    <= RST_VAL;
        end else begin
            stage1Q <= din;
            dout    <= stage1Q;
        end
    end
endmodule : eep_sync

// >>> verilog/eep_prog_timer.sv
`timescale 1ns/1ps
module eep_prog_timer #(
    parameter int unsigned SHORT_CYC = 2,
    parameter int unsigned LONG_CYC  = 4
) (
    input  wire logic sys_clk, // System clock.
    input  wire logic sys_rst, // Synchronous reset.
    input  wire logic start,   // Pulse that begins a programming cycle.
    input  wire logic useLong, // Select the doubled programming time.
    output logic      busy     // High while programming.
);
    localparam int CW = $clog2(LONG_CYC + 1);
    logic [CW-1:0] cntQ;

    // Self-timed from the system clock; no serial clock needed.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cntQ <= '0;
            busy <= 1'b0;
        end else if (start && !busy) begin
            cntQ <= useLong ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
            busy <= 1'b1;
        end else if (busy) begin
            if (cntQ == '0) begin
                busy <= 1'b0;
            end else begin
                cntQ <= cntQ - 1'b1;
            end
        end
    end
endmodule : eep_prog_timer

// >>> test/eep_bus_master.sv
`timescale 1ns/1ps
module eep_bus_master (
    input  wire logic sysClk,  // Bench clock.
    input  wire logic sdaLine, // Resolved data wire.
    output logic      scl,     // Serial clock.
    output logic      sdaPull  // High pulls data low.
);
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // Clock and data never move on one edge, so no false START or STOP is seen.
    task automatic step(input logic c, input logic p);
        scl <= c;
        sdaPull <= p;
        repeat (4) @(posedge sysClk);
    endtask : step
    task automatic startCond;
        step(1'b0, sdaPull);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : startCond
    task automatic stopCond;
        step(1'b0, sdaPull);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stopCond
    task automatic xfer(input logic b, output logic s);
        step(1'b0, sdaPull);
        step(1'b0, !b);
        step(1'b1, !b);
        step(1'b1, !b);
        s = sdaLine;
    endtask : xfer
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, s);
        ack = !s;
    endtask : sendByte
    task automatic recvByte(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(!ackIt, s);
    endtask : recvByte
endmodule : eep_bus_master

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    import eep_pkg::*;
    localparam logic [3:0] SEL_TYPE = 4'h5; // Arbitrary type code.
    logic        sysClk = 1'b0;
    logic        sysRst = 1'b1;
    logic        writeMode = 1'b0;
    logic [2:0]  straps = 3'h5;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awready, wready, bvalid, arready, rvalid, sdaOe, scl, sdaPull, ack;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  expMem [256];
    int          nErrors = 0, samplesChecked = 0, cycles = 0, acks;
    wire         sdaLine = !(sdaOe || sdaPull);
    always #2.5 sysClk = ~sysClk;
    eep_serial_slave #(.TYPE_CODE(SEL_TYPE), .PROG_SHORT_CYC(400), .PROG_LONG_CYC(800))
    u_eep_serial_slave (
        .sys_clk(sysClk), .sys_rst(sysRst), .scl(scl), .sdaIn(sdaLine), .sdaOut(),
        .sdaOe(sdaOe), .writeMode(writeMode), .chipSelectStraps(straps),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
    eep_bus_master u_eep_bus_master (
        .sysClk(sysClk), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        forever begin
            @(posedge sysClk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axiWrite
    task automatic axiRead(input logic [7:0] a);
        @(posedge sysClk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever begin
            @(posedge sysClk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : axiRead
    task automatic waitIdle;
        rd = 32'h1;
        for (int i = 0; i < 400 && rd[STAT_BUSY_BIT] !== 1'b0; i++) axiRead(REG_STATUS);
        check(rd[STAT_BUSY_BIT], 1'b0);
    endtask : waitIdle
    function automatic logic [7:0] sel(input logic rw);
        return {SEL_TYPE, straps, rw};
    endfunction : sel
    task automatic writeBytes(input logic [7:0] a, input int n, input logic [7:0] base);
        acks = 0;
        u_eep_bus_master.startCond();
        u_eep_bus_master.sendByte(sel(1'b0), ack);
        acks += ack;
        u_eep_bus_master.sendByte(a, ack);
        acks += ack;
        for (int i = 0; i < n; i++) begin
            u_eep_bus_master.sendByte(base + 8'(i), ack);
            acks += ack;
        end
        u_eep_bus_master.stopCond();
    endtask : writeBytes
    task automatic readBytes(input logic [7:0] a, input logic rnd, input int n);
        logic [7:0] d;
        if (rnd) begin
            u_eep_bus_master.startCond();
            u_eep_bus_master.sendByte(sel(1'b0), ack);
            u_eep_bus_master.sendByte(a, ack);
        end
        u_eep_bus_master.startCond();
        u_eep_bus_master.sendByte(sel(1'b1), ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_eep_bus_master.recvByte(i < n - 1, d);
            check(d, expMem[a + 8'(i)]);
        end
        u_eep_bus_master.stopCond();
    endtask : readBytes
    task automatic testRegs;
        axiRead(REG_CTRL);
        check(rd[CTRL_EN_BIT], CTRL_EN_RESET);
        axiRead(8'h08);
        check(resp, RESP_SLVERR);
        check(rd, 32'h0);
        axiWrite(REG_CTRL, 32'h0);
        check(resp, RESP_OKAY);
        writeBytes(8'h00, 0, 8'h00);
        check(acks, 0);
        axiWrite(REG_CTRL, 32'h1);
        $display("testRegs done");
    endtask : testRegs
    task automatic testSelect;
        u_eep_bus_master.startCond();
        u_eep_bus_master.sendByte({SEL_TYPE, ~straps, 1'b0}, ack);
        check(ack, 1'b0);
        u_eep_bus_master.startCond();
        u_eep_bus_master.sendByte({~SEL_TYPE, straps, 1'b0}, ack);
        check(ack, 1'b0);
        u_eep_bus_master.stopCond();
        $display("testSelect done");
    endtask : testSelect
    task automatic testByte;
        writeMode <= 1'b1;
        writeBytes(8'h10, 1, 8'ha5);
        check(acks, 3);
        axiRead(REG_STATUS);
        check(rd[STAT_BUSY_BIT], 1'b1);
        check(rd[STAT_ADDR_LSB+7:STAT_ADDR_LSB], 8'h11);
        check(rd[STAT_MODE_BIT], 1'b1);
        writeBytes(8'h00, 0, 8'h00);
        check(acks, 0);
        waitIdle();
        writeMode <= 1'b0;
        writeBytes(8'h11, 1, 8'h5a);
        check(acks, 3);
        waitIdle();
        expMem[8'h10] = 8'ha5;
        expMem[8'h11] = 8'h5a;
        readBytes(8'h10, 1'b1, 1);
        readBytes(8'h11, 1'b0, 1);
        $display("testByte done");
    endtask : testByte
    task automatic testPage;
        writeBytes(8'h26, 9, 8'h30);
        check(acks, 10);
        waitIdle();
        for (int i = 0; i < 8; i++) expMem[8'h20 + 8'((i + 6) % 8)] = 8'h30 + 8'(i);
        readBytes(8'h20, 1'b1, 8);
        $display("testPage done");
    endtask : testPage
    task automatic testMulti;
        writeMode <= 1'b1;
        writeBytes(8'h7e, 5, 8'h60);
        check(acks, 6);
        waitIdle();
        for (int i = 0; i < 4; i++) expMem[8'h7e + 8'(i)] = 8'h60 + 8'(i);
        readBytes(8'h7e, 1'b1, 4);
        $display("testMulti done");
    endtask : testMulti
    task automatic reportAndStop;
        $display("checks=%0d errors=%0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : reportAndStop
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 40000) begin
            nErrors++;
            reportAndStop();
        end
    end
    initial begin
        repeat (6) @(posedge sysClk);
        sysRst <= 1'b0;
        repeat (3) @(posedge sysClk);
        testRegs();
        testSelect();
        testByte();
        testPage();
        testMulti();
        reportAndStop();
    end
endmodule : tb
